// ---- rsc_map.vh ----
// Register map, field positions, reset values and timing counts for reset source control
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RSC_ADDR_CAUSE 8'h00
`define RSC_ADDR_CONFIG 8'h04
`define RSC_ADDR_IRQ_STATUS 8'h08
`define RSC_ADDR_IRQ_MASK 8'h0C
`define RSC_ADDR_STATE 8'h10

// ****************************************************************
// Cause register fields (flags are active low where marked _n)
// ****************************************************************
`define RSC_CAUSE_BROWNOUT_N 0
`define RSC_CAUSE_SOFT_N 1
`define RSC_CAUSE_STACK_UNDER 2
`define RSC_CAUSE_STACK_OVER 3
`define RSC_CAUSE_TIMEOUT_N 4
`define RSC_CAUSE_POWERDOWN_N 5
`define RSC_CAUSE_POR_N 6
`define RSC_CAUSE_PIN_N 7
`define RSC_CAUSE_W 8
`define RSC_CAUSE_POR_VALUE 8'h30

// ****************************************************************
// Config register fields
// ****************************************************************
`define RSC_CFG_LOW_POWER_BROWNOUT_DETECTOR_EN 0
`define RSC_CFG_PIN_EN 1
`define RSC_CFG_LVP 2
`define RSC_CFG_STACK_EN 3
`define RSC_CFG_PWRT_EN_N 4
`define RSC_CFG_PULLUP_SW 5
`define RSC_CFG_W 6
`define RSC_CFG_RESET 6'h3C

// ****************************************************************
// Interrupt status / mask fields (one per reset source event)
// ****************************************************************
`define RSC_EV_BROWNOUT 0
`define RSC_EV_PIN 1
`define RSC_EV_WATCHDOG 2
`define RSC_EV_SOFT 3
`define RSC_EV_STACK 4
`define RSC_EV_PROG_EXIT 5
`define RSC_EV_W 6

// ****************************************************************
// Timing
// ****************************************************************
`define RSC_CLK_HZ 20000000
`define RSC_PWRT_US 64
`define RSC_PWRT_CYCLES ((`RSC_PWRT_US * (`RSC_CLK_HZ / 1000000)))
`define RSC_START_CYCLES 10
`define RSC_FILTER_CYCLES 4

`endif

// ---- rsc_pin_filter.v ----
// Glitch filter for the external reset pin
`timescale 1ns/1ns
module rsc_pin_filter #(
	parameter FILT = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire pin_in,
	output reg pin_low_q
);
	reg [7:0] cnt_q;

	// Low must persist FILT cycles to count; release is also filtered
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 8'h00;
			pin_low_q <= 1'b0;
		end else if (pin_in == pin_low_q) begin
			if (cnt_q == FILT[7:0] - 8'h01) begin
				cnt_q <= 8'h00;
				pin_low_q <= ~pin_low_q;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end else begin
			cnt_q <= 8'h00;
		end
	end
endmodule // rsc_pin_filter

// ---- rsc_reset_source_control.v ----
// Reset source control: combines reset sources, cause flags, power-up delay, AXI4-Lite regs
`timescale 1ns/1ns
`include "rsc_map.vh"

module rsc_reset_source_control #(
	parameter PWRT_CYCLES = `RSC_PWRT_CYCLES,
	parameter START_CYCLES = `RSC_START_CYCLES,
	parameter FILTER_CYCLES = `RSC_FILTER_CYCLES
) (
	input wire aclk,
	input wire aresetn,
	input wire low_power_brownout_detector,
	input wire main_brownout_low,
	input wire external_reset_pin_in,
	output reg external_reset_pin_out,
	output reg external_reset_pin_oe_n,
	output reg pin_pullup_en,
	input wire watchdog_timeout,
	input wire soft_reset_req,
	input wire stack_overflow,
	input wire stack_underflow,
	input wire prog_mode_exit,
	output reg core_reset_q,
	output reg irq,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	localparam [3:0] ST_PWRT = 4'b0001;
	localparam [3:0] ST_PIN = 4'b0010;
	localparam [3:0] ST_START = 4'b0100;
	localparam [3:0] ST_RUN = 4'b1000;

	function [`RSC_CAUSE_W-1:0] apply_wstrb;
		input [`RSC_CAUSE_W-1:0] old;
		input [31:0] data;
		input [3:0] strb;
		begin
			apply_wstrb = strb[0] ? data[`RSC_CAUSE_W-1:0] : old;
		end
	endfunction

	reg [3:0] state_q;
	reg [31:0] cnt_q;
	reg [`RSC_CAUSE_W-1:0] cause_q;
	reg [`RSC_CFG_W-1:0] cfg_q;
	reg [`RSC_EV_W-1:0] ev_status_q;
	reg [`RSC_EV_W-1:0] ev_mask_q;
	reg aw_held_q;
	reg w_held_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire pin_low;
	wire pin_en;
	wire low_power_brownout_detector_hit;
	wire stack_hit;
	wire pin_hit;
	wire por_like;
	wire warm_hit;
	wire [`RSC_EV_W-1:0] ev_set;
	wire wr_go;
	wire rd_go;
	wire rd_status;

	rsc_pin_filter #(
		.FILT(FILTER_CYCLES)
	) u_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(external_reset_pin_in),
		.pin_low_q(pin_low)
	);

	// ****************************************************************
	// Reset source combination
	// ****************************************************************
	assign pin_en = cfg_q[`RSC_CFG_PIN_EN] | cfg_q[`RSC_CFG_LVP];
	assign pin_hit = pin_en & pin_low;
	assign low_power_brownout_detector_hit = cfg_q[`RSC_CFG_LOW_POWER_BROWNOUT_DETECTOR_EN] & low_power_brownout_detector;
	assign stack_hit = cfg_q[`RSC_CFG_STACK_EN] & (stack_overflow | stack_underflow);
	// Brown-out and programming exit restart the full power-up sequence
	assign por_like = low_power_brownout_detector_hit | main_brownout_low | prog_mode_exit;
	assign warm_hit = watchdog_timeout | soft_reset_req | stack_hit;
	assign ev_set = {prog_mode_exit, stack_hit, soft_reset_req, watchdog_timeout,
		pin_hit, low_power_brownout_detector_hit | main_brownout_low};

	// ****************************************************************
	// Start-up sequencer
	// ****************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_PWRT;
			cnt_q <= 32'h00000000;
			core_reset_q <= 1'b1;
		end else if (por_like) begin
			state_q <= ST_PWRT;
			cnt_q <= 32'h00000000;
			core_reset_q <= 1'b1;
		end else if (warm_hit | (pin_hit & (state_q != ST_PWRT))) begin
			state_q <= ST_PIN;
			cnt_q <= 32'h00000000;
			core_reset_q <= 1'b1;
		end else begin
			case (state_q)
				ST_PWRT: begin
					// Timer counts whatever the pin does
					// Pin low here does not restart the timer; ST_PIN then waits for release
					if (cfg_q[`RSC_CFG_PWRT_EN_N] || cnt_q >= PWRT_CYCLES) begin
						state_q <= ST_PIN;
						cnt_q <= 32'h00000000;
					end else begin
						cnt_q <= cnt_q + 32'h00000001;
					end
				end
				ST_PIN: begin
					state_q <= ST_START;
					cnt_q <= 32'h00000000;
				end
				ST_START: begin
					if (cnt_q >= START_CYCLES - 1) begin
						state_q <= ST_RUN;
						core_reset_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q + 32'h00000001;
					end
				end
				ST_RUN: begin
					core_reset_q <= 1'b0;
				end
				default: begin
					state_q <= ST_PWRT;
				end
			endcase
		end
	end

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			external_reset_pin_out <= 1'b0;
			external_reset_pin_oe_n <= 1'b1;
			pin_pullup_en <= 1'b1;
		end else begin
			external_reset_pin_out <= 1'b0;
			external_reset_pin_oe_n <= 1'b1;
			pin_pullup_en <= pin_en | cfg_q[`RSC_CFG_PULLUP_SW];
		end
	end

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
	assign rd_go = s_axi_arvalid & s_axi_arready;
	assign rd_status = rd_go && (s_axi_araddr[7:0] == `RSC_ADDR_IRQ_STATUS);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h00000000;
		end else begin
			s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_q)
					`RSC_ADDR_CAUSE, `RSC_ADDR_CONFIG, `RSC_ADDR_IRQ_MASK: s_axi_bresp <= 2'b00;
					default: s_axi_bresp <= 2'b10;
				endcase
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr[7:0])
					`RSC_ADDR_CAUSE: s_axi_rdata <= {24'h000000, cause_q};
					`RSC_ADDR_CONFIG: s_axi_rdata <= {26'h0000000, cfg_q};
					`RSC_ADDR_IRQ_STATUS: s_axi_rdata <= {26'h0000000, ev_status_q};
					`RSC_ADDR_IRQ_MASK: s_axi_rdata <= {26'h0000000, ev_mask_q};
					`RSC_ADDR_STATE: s_axi_rdata <= {27'h0000000, core_reset_q, state_q};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Cause flags, config, interrupts
	// ****************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			cause_q <= `RSC_CAUSE_POR_VALUE;
			cfg_q <= `RSC_CFG_RESET;
			ev_mask_q <= {`RSC_EV_W{1'b0}};
			ev_status_q <= {`RSC_EV_W{1'b0}};
			irq <= 1'b0;
		end else begin
			if (wr_go && awaddr_q == `RSC_ADDR_CONFIG && wstrb_q[0])
				cfg_q <= wdata_q[`RSC_CFG_W-1:0];
			if (wr_go && awaddr_q == `RSC_ADDR_IRQ_MASK && wstrb_q[0])
				ev_mask_q <= wdata_q[`RSC_EV_W-1:0];
			// Hardware events are applied after the write so they win
			if (prog_mode_exit) begin
				cause_q <= `RSC_CAUSE_POR_VALUE;
			end else begin
				if (wr_go && awaddr_q == `RSC_ADDR_CAUSE)
					cause_q <= apply_wstrb(cause_q, wdata_q, wstrb_q);
				if (low_power_brownout_detector_hit | main_brownout_low)
					cause_q[`RSC_CAUSE_BROWNOUT_N] <= 1'b0;
				if (soft_reset_req)
					cause_q[`RSC_CAUSE_SOFT_N] <= 1'b0;
				if (stack_hit & stack_overflow)
					cause_q[`RSC_CAUSE_STACK_OVER] <= 1'b1;
				if (stack_hit & stack_underflow)
					cause_q[`RSC_CAUSE_STACK_UNDER] <= 1'b1;
				if (watchdog_timeout) begin
					cause_q[`RSC_CAUSE_TIMEOUT_N] <= 1'b0;
					cause_q[`RSC_CAUSE_POWERDOWN_N] <= 1'b1;
				end
				if (pin_hit)
					cause_q[`RSC_CAUSE_PIN_N] <= 1'b0;
			end
			// Read clears, but a same-cycle event survives
			ev_status_q <= (rd_status ? {`RSC_EV_W{1'b0}} : ev_status_q) | ev_set;
			irq <= |(((rd_status ? {`RSC_EV_W{1'b0}} : ev_status_q) | ev_set) & ev_mask_q);
		end
	end
endmodule // rsc_reset_source_control

// ---- rsc_asserts.sv ----
// Port checker for the reset source control block
`timescale 1ns/1ns
module rsc_asserts (
	input wire aclk,
	input wire aresetn,
	input wire main_brownout_low,
	input wire watchdog_timeout,
	input wire soft_reset_req,
	input wire prog_mode_exit,
	input wire external_reset_pin_oe_n,
	input wire core_reset_q,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire src_any = main_brownout_low | watchdog_timeout | soft_reset_req | prog_mode_exit;
	sequence src_ends;
		src_any ##1 !src_any;
	endsequence
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	AST_NO_PIN_DRIVE: assert property (external_reset_pin_oe_n)
		else $error("reset pin output enabled");
	AST_SOFT_RST: assert property (soft_reset_req |=> core_reset_q)
		else $error("soft request gave no reset");
	AST_WDT_RST: assert property (watchdog_timeout |=> core_reset_q)
		else $error("watchdog gave no reset");
	AST_BO_RST: assert property (main_brownout_low |=> core_reset_q)
		else $error("brownout gave no reset");
	AST_PROG_RST: assert property (prog_mode_exit |=> core_reset_q)
		else $error("programming exit gave no reset");
	AST_START_HOLD: assert property (src_ends |=> core_reset_q [*8])
		else $error("reset released too early");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_AR_ANSWER: assert property (ar_taken |=> s_axi_rvalid)
		else $error("read answer late");
endmodule // rsc_asserts

bind rsc_reset_source_control rsc_asserts i_chk (.*);

// ---- rsc_far_model.sv ----
// Far side: reset pin driver and supply monitors
`timescale 1ns/1ns
module rsc_far_model (
	input wire aclk,
	input wire external_reset_pin_out,
	input wire external_reset_pin_oe_n,
	input wire pin_pullup_en,
	output wire external_reset_pin_in,
	output logic low_power_brownout_detector,
	output logic main_brownout_low
);
	logic drv = 1'h0;
	logic tgl = 1'h0;
	initial {low_power_brownout_detector, main_brownout_low} = 2'h0;
	// An unpulled floating pin must not settle to a lucky level
	always @(posedge aclk) tgl <= ~tgl;
	assign external_reset_pin_in = !external_reset_pin_oe_n ? external_reset_pin_out :
		drv ? 1'h0 : pin_pullup_en ? 1'h1 : tgl;
	task pin_low(input int n);
		drv <= 1'h1;
		repeat (n) @(posedge aclk);
		drv <= 1'h0;
	endtask
	task supply_low(input logic lp, input int n);
		if (lp) low_power_brownout_detector <= 1'h1;
		else main_brownout_low <= 1'h1;
		repeat (n) @(posedge aclk);
		{low_power_brownout_detector, main_brownout_low} <= 2'h0;
	endtask
endmodule // rsc_far_model

// ---- reset_source_control_tb.sv ----
// Self-checking testbench for reset source control
`timescale 1ns/1ns
`include "rsc_map.vh"
module reset_source_control_tb;
	localparam PW = 8;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic watchdog_timeout = 1'h0, soft_reset_req = 1'h0, stack_overflow = 1'h0;
	logic stack_underflow = 1'h0, prog_mode_exit = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	wire low_power_brownout_detector, main_brownout_low, external_reset_pin_in;
	wire external_reset_pin_out, external_reset_pin_oe_n, pin_pullup_en, core_reset_q, irq;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	logic [31:0] rd;
	logic [1:0] rs;
	int fails = 0;
	int checks_done = 0;
	rsc_reset_source_control #(.PWRT_CYCLES(PW)) i_dut (.*);
	rsc_far_model i_far (.*);
	always #25 aclk = ~aclk;
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		ta = 0;
		tw = 0;
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (s_axi_awready) ta = 1;
			if (s_axi_wready) tw = 1;
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid) @(posedge aclk);
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task rd_reg(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		while (!s_axi_rvalid) @(posedge aclk);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task fire(input int k);
		@(posedge aclk);
		case (k)
		0: soft_reset_req <= 1'h1;
		1: watchdog_timeout <= 1'h1;
		2: stack_overflow <= 1'h1;
		3: stack_underflow <= 1'h1;
		default: prog_mode_exit <= 1'h1;
		endcase
		@(posedge aclk);
		{soft_reset_req, watchdog_timeout, stack_overflow, stack_underflow, prog_mode_exit} <= 5'h0;
	endtask
	// Counts negedges from the last source edge until the core reset drops
	task settle(output int n);
		repeat (2) @(negedge aclk);
		check(core_reset_q, 1'h1);
		n = 2;
		while (core_reset_q) begin
			@(negedge aclk);
			n++;
		end
	endtask
	task ev(input int k, input logic [7:0] cfg, input logic [7:0] ce, input int lo, input int hi);
		int n;
		wr(`RSC_ADDR_CONFIG, {24'h0, cfg});
		wr(`RSC_ADDR_CAUSE, 32'hF3);
		case (k)
		5: i_far.pin_low(20);
		6: i_far.supply_low(1'h1, 4);
		7: i_far.pin_low(2);
		8: i_far.supply_low(1'h0, 4);
		default: fire(k);
		endcase
		if (hi == 0) begin
			repeat (8) @(negedge aclk);
			check(core_reset_q, 1'h0);
		end else begin
			settle(n);
			check(n >= lo && n <= hi, 1'h1);
		end
		rd_reg(`RSC_ADDR_CAUSE);
		if (ce != 8'h0) check(rd, {24'h0, ce});
	endtask
	task report_and_stop;
		$display("checks_done %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		while (core_reset_q !== 1'h0) @(posedge aclk);
		check(external_reset_pin_oe_n, 1'h1);
		check(pin_pullup_en, 1'h1);
		rd_reg(`RSC_ADDR_CAUSE);
		check(rd, `RSC_CAUSE_POR_VALUE);
		rd_reg(`RSC_ADDR_CONFIG);
		check(rd, `RSC_CFG_RESET);
		rd_reg(8'h14);
		check(rd, 32'h0);
		check({30'h0, rs}, 32'h2);
		wr(`RSC_ADDR_IRQ_STATUS, 32'h3F);
		check(rs, 2'h2);
		ev(0, 8'h3C, 8'hF1, 12, 12);
		check(irq, 1'h0);
		wr(`RSC_ADDR_IRQ_MASK, 32'h3F);
		repeat (2) @(negedge aclk);
		check(irq, 1'h1);
		rd_reg(`RSC_ADDR_IRQ_STATUS);
		check(rd, 32'h08);
		repeat (2) @(negedge aclk);
		check(irq, 1'h0);
		ev(1, 8'h3C, 8'hE3, 12, 12);
		ev(2, 8'h34, 8'hF3, 0, 0);
		ev(2, 8'h3C, 8'hFB, 12, 12);
		ev(3, 8'h3C, 8'hF7, 12, 12);
		ev(5, 8'h3C, 8'h73, 12, 20);
		ev(7, 8'h3C, 8'hF3, 0, 0);
		ev(5, 8'h38, 8'hF3, 0, 0);
		check(pin_pullup_en, 1'h1);
		wr(`RSC_ADDR_CONFIG, 32'h18);
		repeat (2) @(negedge aclk);
		check(pin_pullup_en, 1'h0);
		ev(5, 8'h1A, 8'h73, 12, 20);
		ev(6, 8'h3C, 8'hF3, 0, 0);
		ev(6, 8'h3D, 8'hF2, 12, 15);
		ev(8, 8'h2C, 8'h00, 12 + PW, 15 + PW);
		ev(4, 8'h2C, 8'h00, 12 + PW, 15 + PW);
		report_and_stop;
	end
	initial begin
		#250000;
		fails++;
		report_and_stop;
	end
endmodule // reset_source_control_tb
